// File: tpsoc_pkg.sv
`default_nettype none
package tpsoc_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int CNT_W = 8;

   localparam logic [ADDR_W-1:0] CH0_ADDR = 16'hFFB2;
   localparam logic [ADDR_W-1:0] CH1_ADDR = 16'hFFB3;
   localparam logic [ADDR_W-1:0] EVT_ADDR = 16'hFFC0;
   localparam logic [ADDR_W-1:0] MASK_ADDR = 16'hFFC1;

   localparam int FLAG_LSB = 5;
   localparam int TRIG_BIT = 4;
   localparam int ACT_A_LSB = 0;
   localparam int ACT_B_LSB = 2;

   localparam logic [CNT_W-1:0] CNT_TOP = 8'hFF;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

   localparam logic CH1_RSVD_VAL = 1'b1;
   localparam logic [4:0] CTL_RST = 5'h00;
   localparam logic [2:0] FLAG_RST = 3'h0;
   localparam logic [5:0] EVT_RST = 6'h00;
   localparam logic [5:0] MASK_RST = 6'h00;
   localparam logic PIN_RST = 1'b0;

   typedef enum logic [1:0] {
      TPSOC_KEEP = 2'b00,
      TPSOC_LOW = 2'b01,
      TPSOC_HIGH = 2'b10,
      TPSOC_TOGGLE = 2'b11
   } tpsoc_act_t;

   // Bit order matches status bits 7:5
   typedef struct packed {
      logic b;
      logic a;
      logic wrap;
   } tpsoc_evt_t;

   typedef struct packed {
      logic b;
      logic a;
   } tpsoc_mt_t;

   typedef struct packed {
      logic eq_a;
      logic eq_b;
      logic at_top;
   } tpsoc_det_t;

   typedef struct packed {
      logic pin;
   } tpsoc_pin_t;

   typedef struct packed {
      logic [1:0][4:0] ctl;
      tpsoc_evt_t [1:0] flag;
      tpsoc_evt_t [1:0] arm;
      logic [5:0] evt;
      logic [5:0] mask;
      logic [DATA_W-1:0] rdata;
      tpsoc_evt_t [1:0] irq;
      logic conv;
      logic int_l;
   } tpsoc_top_t;

   localparam tpsoc_det_t DET_RST = '0;
endpackage
`default_nettype wire

// File: tpsoc_detect.sv
`timescale 1ns/1ns
`default_nettype none
module tpsoc_detect (
   input wire logic sys_clk_in, // System clock
   input wire logic rstn_in, // Sync reset, active low
   input wire logic [7:0] byte_counter_in, // Channel counter
   input wire logic [7:0] compare_constant_a_in, // Compare constant A
   input wire logic [7:0] compare_constant_b_in, // Compare constant B
   output tpsoc_pkg::tpsoc_evt_t event_out // One-cycle events
);
   import tpsoc_pkg::*;

   tpsoc_det_t s_q;
   tpsoc_det_t s_d;

   always_comb begin
      s_d.eq_a = (byte_counter_in == compare_constant_a_in);
      s_d.eq_b = (byte_counter_in == compare_constant_b_in);
      s_d.at_top = (byte_counter_in == CNT_TOP);
      // Only the first cycle of equality counts, so a stalled counter
      // does not keep re-raising a flag software just cleared
      event_out.a = s_d.eq_a && !s_q.eq_a;
      event_out.b = s_d.eq_b && !s_q.eq_b;
      event_out.wrap = s_q.at_top && (byte_counter_in == CNT_ZERO);
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         s_q <= DET_RST;
      end else begin
         s_q <= s_d;
      end
   end
endmodule
`default_nettype wire

// File: tpsoc_pin.sv
`timescale 1ns/1ns
`default_nettype none
module tpsoc_pin (
   input wire logic sys_clk_in, // System clock
   input wire logic rstn_in, // Sync reset, active low
   input wire tpsoc_pkg::tpsoc_evt_t event_in, // Match events
   input wire tpsoc_pkg::tpsoc_act_t match_a_action_in, // Action on A
   input wire tpsoc_pkg::tpsoc_act_t match_b_action_in, // Action on B
   output logic pin_out // Compare output pin level
);
   import tpsoc_pkg::*;

   tpsoc_pin_t s_q;
   tpsoc_pin_t s_d;

   function automatic logic apply(input logic cur, input tpsoc_act_t code);
      case (code)
         TPSOC_KEEP: apply = cur;
         TPSOC_LOW: apply = 1'b0;
         TPSOC_HIGH: apply = 1'b1;
         TPSOC_TOGGLE: apply = ~cur;
         default: apply = cur;
      endcase
   endfunction

   always_comb begin
      s_d = s_q;
      // Both at once: A applied first, B on top of it
      if (event_in.a) begin
         s_d.pin = apply(s_d.pin, match_a_action_in);
      end
      if (event_in.b) begin
         s_d.pin = apply(s_d.pin, match_b_action_in);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         s_q.pin <= PIN_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign pin_out = s_q.pin;
endmodule
`default_nettype wire

// File: tpsoc_top.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tpsoc_top (
   input wire logic sys_clk_in, // 250 MHz system clock
   input wire logic rstn_in, // Sync reset, active low
   input wire logic [tpsoc_pkg::ADDR_W-1:0] addr_in, // Register address
   input wire logic [tpsoc_pkg::DATA_W-1:0] wdata_in, // Write data
   input wire logic wr_in, // Write strobe
   input wire logic rd_in, // Read strobe
   output logic [tpsoc_pkg::DATA_W-1:0] rdata_out, // Read data, next cycle
   input wire logic [1:0][7:0] byte_counter_in, // Counters per channel
   input wire logic [1:0][7:0] compare_constant_a_in, // Constants A
   input wire logic [1:0][7:0] compare_constant_b_in, // Constants B
   input wire tpsoc_pkg::tpsoc_evt_t [1:0] irq_enable_in, // Irq enables
   input wire tpsoc_pkg::tpsoc_mt_t [1:0] xfer_clear_in, // Unit clear
   input wire tpsoc_pkg::tpsoc_mt_t [1:0] transfer_irq_select_in, // Sel
   input wire tpsoc_pkg::tpsoc_mt_t [1:0] xfer_count_nz_in, // Count > 0
   output tpsoc_pkg::tpsoc_evt_t [1:0] irq_out, // Per-flag requests
   output logic [1:0] pin_out, // Compare output pins
   output logic conv_start_out, // Conversion start pulse
   output logic int_out // Combined event interrupt
);
   import tpsoc_pkg::*;

   tpsoc_top_t s_q;
   tpsoc_top_t s_d;
   tpsoc_evt_t [1:0] det_evt;
   logic [1:0] wr_ch;
   logic [1:0] rd_ch;
   tpsoc_evt_t [1:0] clr;

   function automatic logic chan_hit(input logic [ADDR_W-1:0] a,
                                     input logic ch);
      chan_hit = (a == (ch ? CH1_ADDR : CH0_ADDR));
   endfunction

   function automatic logic [DATA_W-1:0] status_byte(input tpsoc_evt_t f,
                                                     input logic [4:0] c,
                                                     input logic ch);
      status_byte = {f, (ch ? CH1_RSVD_VAL : c[TRIG_BIT]), c[3:0]};
   endfunction

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         tpsoc_detect u_det (
            .sys_clk_in(sys_clk_in),
            .rstn_in(rstn_in),
            .byte_counter_in(byte_counter_in[g]),
            .compare_constant_a_in(compare_constant_a_in[g]),
            .compare_constant_b_in(compare_constant_b_in[g]),
            .event_out(det_evt[g])
         );
         tpsoc_pin u_pin (
            .sys_clk_in(sys_clk_in),
            .rstn_in(rstn_in),
            .event_in(det_evt[g]),
            .match_a_action_in(tpsoc_act_t'(s_q.ctl[g][ACT_A_LSB+:2])),
            .match_b_action_in(tpsoc_act_t'(s_q.ctl[g][ACT_B_LSB+:2])),
            .pin_out(pin_out[g])
         );
      end
   endgenerate

   always_comb begin
      s_d = s_q;
      wr_ch = '0;
      rd_ch = '0;
      clr = '0;
      s_d.rdata = '0;
      for (int ch = 0; ch < 2; ch++) begin
         wr_ch[ch] = wr_in && chan_hit(addr_in, ch[0]);
         rd_ch[ch] = rd_in && chan_hit(addr_in, ch[0]);
         // Only bits seen as one by an earlier read may be cleared by a write
         if (wr_ch[ch]) begin
            clr[ch] = ~wdata_in[FLAG_LSB+:3] & s_q.arm[ch];
         end
         if (xfer_clear_in[ch].a && !transfer_irq_select_in[ch].a &&
             xfer_count_nz_in[ch].a) begin
            clr[ch].a = 1'b1;
         end
         if (xfer_clear_in[ch].b && !transfer_irq_select_in[ch].b &&
             xfer_count_nz_in[ch].b) begin
            clr[ch].b = 1'b1;
         end
         // New event wins over a clear in the same cycle
         s_d.flag[ch] = det_evt[ch] | (s_q.flag[ch] & ~clr[ch]);
         if (wr_ch[ch]) begin
            s_d.arm[ch] = '0;
            s_d.ctl[ch][3:0] = wdata_in[3:0];
            if (ch == 0) begin
               s_d.ctl[ch][TRIG_BIT] = wdata_in[TRIG_BIT];
            end
         end else if (rd_ch[ch]) begin
            s_d.arm[ch] = s_q.arm[ch] | s_q.flag[ch];
            s_d.rdata = status_byte(s_q.flag[ch], s_q.ctl[ch], ch[0]);
         end
         // A flag cleared by other means needs a fresh read
         s_d.arm[ch] = s_d.arm[ch] & s_d.flag[ch];
         s_d.irq[ch] = s_d.flag[ch] & irq_enable_in[ch];
      end

      s_d.conv = det_evt[0].a && s_q.ctl[0][TRIG_BIT];

      if (wr_in && addr_in == EVT_ADDR) begin
         s_d.evt = s_q.evt & ~wdata_in[5:0];
      end
      if (wr_in && addr_in == MASK_ADDR) begin
         s_d.mask = wdata_in[5:0];
      end
      s_d.evt = s_d.evt | {det_evt[1], det_evt[0]};
      if (rd_in && addr_in == EVT_ADDR) begin
         s_d.rdata = {2'b00, s_q.evt};
      end
      if (rd_in && addr_in == MASK_ADDR) begin
         s_d.rdata = {2'b00, s_q.mask};
      end
      s_d.int_l = |(s_d.evt & s_d.mask);
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         s_q.ctl <= {CTL_RST, CTL_RST};
         s_q.flag <= {FLAG_RST, FLAG_RST};
         s_q.arm <= {FLAG_RST, FLAG_RST};
         s_q.evt <= EVT_RST;
         s_q.mask <= MASK_RST;
         s_q.rdata <= '0;
         s_q.irq <= {FLAG_RST, FLAG_RST};
         s_q.conv <= 1'b0;
         s_q.int_l <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_out = s_q.rdata;
   assign irq_out = s_q.irq;
   // Converter side decides whether to honour this pulse
   assign conv_start_out = s_q.conv;
   assign int_out = s_q.int_l;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rstn_in);

   a_match_a_set: assert property (
      (byte_counter_in[0] != compare_constant_a_in[0]) ##1
      (byte_counter_in[0] == compare_constant_a_in[0])
      |=> s_q.flag[0].a)
      else $error("match A flag not set on equality");

   a_match_b_set: assert property (
      (byte_counter_in[1] != compare_constant_b_in[1]) ##1
      (byte_counter_in[1] == compare_constant_b_in[1])
      |=> s_q.flag[1].b)
      else $error("match B flag not set on equality");

   a_write_one_keeps: assert property (
      wr_in && addr_in == CH0_ADDR && wdata_in[7] && s_q.flag[0].b &&
      !xfer_clear_in[0].b
      |=> s_q.flag[0].b)
      else $error("writing one changed a flag");

   a_unread_keeps: assert property (
      wr_in && addr_in == CH1_ADDR && !wdata_in[5] &&
      s_q.flag[1].wrap && !s_q.arm[1].wrap
      |=> s_q.flag[1].wrap)
      else $error("flag cleared without a prior read");

   a_read_then_clear: assert property (
      (rd_in && addr_in == CH0_ADDR && s_q.flag[0].a) ##1
      (wr_in && addr_in == CH0_ADDR && !wdata_in[6] && !det_evt[0].a)
      |=> !s_q.flag[0].a)
      else $error("read then write zero did not clear");

   a_xfer_clear_ok: assert property (
      xfer_clear_in[0].a && !transfer_irq_select_in[0].a &&
      xfer_count_nz_in[0].a && !det_evt[0].a
      |=> !s_q.flag[0].a)
      else $error("transfer unit clear ignored");

   a_xfer_clear_blocked: assert property (
      s_q.flag[0].b && !wr_in && !det_evt[0].b &&
      xfer_clear_in[0].b && !xfer_count_nz_in[0].b
      |=> s_q.flag[0].b)
      else $error("transfer unit cleared with zero count");

   a_conv_on_match: assert property (
      det_evt[0].a && s_q.ctl[0][TRIG_BIT] |=> conv_start_out)
      else $error("no conversion start on enabled match A");

   a_conv_blocked: assert property (
      !s_q.ctl[0][TRIG_BIT] [*2] |-> !conv_start_out)
      else $error("conversion start while disabled");

   a_ch1_rsvd_one: assert property (
      rd_in && addr_in == CH1_ADDR |=> rdata_out[TRIG_BIT])
      else $error("channel 1 bit 4 not read as one");

   a_pin_toggle: assert property (
      det_evt[0].a && !det_evt[0].b &&
      s_q.ctl[0][ACT_A_LSB+:2] == TPSOC_TOGGLE
      |=> pin_out[0] != $past(pin_out[0]))
      else $error("pin did not toggle on match A");

   a_pin_drive_high: assert property (
      det_evt[1].b && s_q.ctl[1][ACT_B_LSB+:2] == TPSOC_HIGH
      |=> pin_out[1])
      else $error("pin not driven high on match B");

   a_wrap_set: assert property (
      byte_counter_in[1] == CNT_TOP ##1 byte_counter_in[1] == CNT_ZERO
      |=> s_q.flag[1].wrap)
      else $error("wrap flag not set on rollover");

   a_irq_follows: assert property (
      (s_q.flag[1].wrap && irq_enable_in[1].wrap) [*2]
      |-> irq_out[1].wrap)
      else $error("irq missing for set and enabled flag");

   a_irq_off: assert property (
      !irq_enable_in[0].a [*2] |-> !irq_out[0].a)
      else $error("irq raised while disabled");

   a_int_level: assert property (
      int_out == |(s_q.evt & s_q.mask))
      else $error("interrupt output disagrees with status");

   a_match_a_set_ch1: assert property (
      (byte_counter_in[1] != compare_constant_a_in[1]) ##1
      (byte_counter_in[1] == compare_constant_a_in[1])
      |=> s_q.flag[1].a)
      else $error("channel 1 match A flag not set");

   a_match_b_set_ch0: assert property (
      (byte_counter_in[0] != compare_constant_b_in[0]) ##1
      (byte_counter_in[0] == compare_constant_b_in[0])
      |=> s_q.flag[0].b)
      else $error("channel 0 match B flag not set");

   a_match_a_only: assert property (
      !s_q.flag[0].a &&
      byte_counter_in[0] != compare_constant_a_in[0]
      |=> !s_q.flag[0].a)
      else $error("match A flag set without equality");

   a_match_b_only: assert property (
      !s_q.flag[1].b &&
      byte_counter_in[1] != compare_constant_b_in[1]
      |=> !s_q.flag[1].b)
      else $error("match B flag set without equality");

   a_wrap_only: assert property (
      !s_q.flag[1].wrap && byte_counter_in[1] != CNT_ZERO
      |=> !s_q.flag[1].wrap)
      else $error("wrap flag set without rollover");

   a_flag_readback: assert property (
      rd_in && addr_in == CH1_ADDR
      |=> rdata_out[FLAG_LSB+:3] == $past(s_q.flag[1]))
      else $error("status read disagrees with flags");

   a_trig_readback: assert property (
      rd_in && addr_in == CH0_ADDR
      |=> rdata_out[TRIG_BIT] == $past(s_q.ctl[0][TRIG_BIT]))
      else $error("channel 0 bit 4 read back wrong");

   a_xfer_sel_blocked: assert property (
      s_q.flag[0].a && !wr_in && !det_evt[0].a &&
      xfer_clear_in[0].a && transfer_irq_select_in[0].a
      |=> s_q.flag[0].a)
      else $error("transfer unit cleared with select set");

   a_conv_single: assert property (
      conv_start_out |=> !conv_start_out)
      else $error("conversion start longer than one cycle");

   a_pin_drive_low: assert property (
      det_evt[0].b && s_q.ctl[0][ACT_B_LSB+:2] == TPSOC_LOW
      |=> !pin_out[0])
      else $error("pin not driven low on match B");

   a_pin_quiet: assert property (
      !det_evt[1].a && !det_evt[1].b |=> $stable(pin_out[1]))
      else $error("pin moved without a match");

   a_irq_b_follows: assert property (
      (s_q.flag[0].b && irq_enable_in[0].b) [*2]
      |-> irq_out[0].b)
      else $error("match B irq missing while enabled");

   a_irq_a_follows: assert property (
      (s_q.flag[0].a && irq_enable_in[0].a) [*2]
      |-> irq_out[0].a)
      else $error("match A irq missing while enabled");
endmodule
`default_nettype wire

// File: tpsoc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin \
   cmp_count++; \
   if ((a) !== (e)) begin \
      miscompares++; \
      $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); \
   end \
end
module tpsoc_top_tb;
   import tpsoc_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic [1:0][7:0] cnt = {8'h10, 8'h10};
   logic [1:0][7:0] ca = {8'h41, 8'h40};
   logic [1:0][7:0] cb = {8'h81, 8'h80};
   tpsoc_evt_t [1:0] ien = {3'h0, 3'h7};
   tpsoc_mt_t [1:0] xclr = '0;
   tpsoc_mt_t [1:0] xsel = '0;
   tpsoc_mt_t [1:0] xnz = '0;
   tpsoc_evt_t [1:0] irq;
   logic [1:0] pin;
   logic conv;
   logic intr;
   int miscompares = 0;
   int cmp_count = 0;
   logic [7:0] ctl;
   logic [1:0] pe = 2'b00;
   // Converter set to accept timer starts
   logic [1:0] conv_trigger_select = 2'b10;
   tpsoc_act_t codes [5] = '{TPSOC_HIGH, TPSOC_TOGGLE, TPSOC_TOGGLE,
                             TPSOC_KEEP, TPSOC_LOW};

   always #2 clk = ~clk;

   tpsoc_top i_dut (
      .sys_clk_in(clk),
      .rstn_in(rstn),
      .addr_in(addr),
      .wdata_in(wdata),
      .wr_in(wr),
      .rd_in(rd),
      .rdata_out(rdata),
      .byte_counter_in(cnt),
      .compare_constant_a_in(ca),
      .compare_constant_b_in(cb),
      .irq_enable_in(ien),
      .xfer_clear_in(xclr),
      .transfer_irq_select_in(xsel),
      .xfer_count_nz_in(xnz),
      .irq_out(irq),
      .pin_out(pin),
      .conv_start_out(conv),
      .int_out(intr)
   );

   // Expected pin level after one match
   function automatic logic act(input tpsoc_act_t c, input logic p);
      case (c)
         TPSOC_LOW: return 1'b0;
         TPSOC_HIGH: return 1'b1;
         TPSOC_TOGGLE: return ~p;
         default: return p;
      endcase
   endfunction

   // Gap cycle after the strobe so back-to-back calls never collide
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e)
      @(posedge clk);
      #1;
      `CHK(rdata, 8'h00)
   endtask

   // Counter steps onto a constant, then leaves for a full cycle
   task automatic hit(input int ch, input bit ab, input logic ep,
                      input logic ec);
      @(posedge clk);
      cnt[ch] <= ab ? cb[ch] : ca[ch];
      @(posedge clk);
      #1;
      `CHK(pin[ch], ep)
      `CHK(conv, ec)
      `CHK(conv & (conv_trigger_select == 2'b10), ec)
      @(posedge clk);
      cnt[ch] <= 8'h10;
      #1;
      `CHK(conv, 1'b0)
      @(posedge clk);
   endtask

   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      results();
   end

   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1;
      `CHK({pin, conv, intr, irq}, 10'h000)
      rd_chk(CH0_ADDR, 8'h00);
      rd_chk(CH1_ADDR, 8'h10);
      rd_chk(EVT_ADDR, 8'h00);
      rd_chk(MASK_ADDR, 8'h00);
      rd_chk(16'hFFB4, 8'h00);
      for (int ch = 0; ch < 2; ch++) begin
         for (int ab = 0; ab < 2; ab++) begin
            for (int i = 0; i < 5; i++) begin
               ctl = {3'b000, 1'(i % 2),
                      ab ? {codes[i], 2'b00} : {2'b00, codes[i]}};
               wr_reg(ch ? CH1_ADDR : CH0_ADDR, ctl);
               pe[ch] = act(codes[i], pe[ch]);
               hit(ch, ab[0], pe[ch], ctl[4] & !(ch | ab));
            end
         end
      end
      rd_chk(EVT_ADDR, 8'h36);
      `CHK(intr, 1'b0)
      wr_reg(MASK_ADDR, 8'h02);
      #1;
      `CHK(intr, 1'b1)
      wr_reg(EVT_ADDR, 8'h02);
      #1;
      `CHK(intr, 1'b0)
      rd_chk(EVT_ADDR, 8'h34);
      wr_reg(MASK_ADDR, 8'h3F);
      #1;
      `CHK(intr, 1'b1)
      wr_reg(EVT_ADDR, 8'h3F);
      #1;
      `CHK(intr, 1'b0)
      rd_chk(MASK_ADDR, 8'h3F);
      // Write of zero without a prior read must not clear
      wr_reg(CH0_ADDR, 8'h04);
      rd_chk(CH0_ADDR, 8'hC4);
      `CHK(irq[0], 3'b110)
      `CHK(irq[1], 3'b000)
      wr_reg(CH0_ADDR, 8'hE4);
      rd_chk(CH0_ADDR, 8'hC4);
      wr_reg(CH0_ADDR, 8'h04);
      rd_chk(CH0_ADDR, 8'h04);
      `CHK(irq[0], 3'b000)
      @(posedge clk);
      ien[1] <= 3'h7;
      cnt[1] <= 8'hFF;
      @(posedge clk);
      cnt[1] <= 8'h00;
      @(posedge clk);
      cnt[1] <= 8'h10;
      @(posedge clk);
      // Unread flags survive a zero write
      wr_reg(CH1_ADDR, 8'h04);
      rd_chk(CH1_ADDR, 8'hF4);
      `CHK(irq[1], 3'b111)
      rd_chk(EVT_ADDR, 8'h08);
      `CHK(intr, 1'b1)
      wr_reg(CH1_ADDR, 8'h04);
      rd_chk(CH1_ADDR, 8'h14);
      `CHK(irq[1], 3'b000)
      hit(0, 1'b0, 1'b0, 1'b0);
      hit(0, 1'b1, 1'b0, 1'b0);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         xsel[0] <= {2{k == 0}};
         xnz[0] <= {2{k != 1}};
         xclr[0] <= 2'b11;
         @(posedge clk);
         xclr[0] <= 2'b00;
         @(posedge clk);
         rd_chk(CH0_ADDR, (k == 2) ? 8'h04 : 8'hC4);
      end
      wr_reg(16'hFFB4, 8'hFF);
      hit(0, 1'b0, 1'b0, 1'b0);
      ien[0] <= 3'h0;
      @(posedge clk);
      @(posedge clk);
      #1;
      `CHK(irq[0], 3'b000)
      // Read strobe followed at once by a clearing write
      @(posedge clk);
      addr <= CH0_ADDR;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b1;
      wdata <= 8'h04;
      #1;
      `CHK(rdata, 8'h44)
      @(posedge clk);
      wr <= 1'b0;
      rd_chk(CH0_ADDR, 8'h04);
      rd_chk(16'hFFB4, 8'h00);
      results();
   end
endmodule
`undef CHK
`default_nettype wire
